/* File: hw/oss_defs.vh */
// constants for the oscillator and system clock source control block
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// register bus geometry
`define OSS_ADDR_W 4
`define OSS_DATA_W 8

// register offsets
`define OSS_OFF_SYS_MODE 4'h0
`define OSS_OFF_SPECIAL 4'h1
`define OSS_OFF_TIMEBASE 4'h2
`define OSS_OFF_STATUS 4'h3

// system_mode_reg fields
`define OSS_SM_DIV_HI 7
`define OSS_SM_DIV_LO 5
`define OSS_SM_FAST_WAKE 4
`define OSS_SM_SLOW_RDY 3
`define OSS_SM_FAST_RDY 2
`define OSS_SM_IDLE_EN 1
`define OSS_SM_FAST_SLOW 0

// reset values
`define OSS_RST_DIV 3'h7
`define OSS_RST_FAST_WAKE 1'b0
`define OSS_RST_IDLE_EN 1'b1
`define OSS_RST_FAST_SLOW 1'b0
`define OSS_RST_PWM_EN 1'b0
`define OSS_RST_QUICK 1'b1

// special_control_reg and timebase_control_reg fields
`define OSS_SC_PWM_EN 0
`define OSS_TB_QUICK 0

// clock source selection codes; 2..7 are the divider codes themselves
`define OSS_SEL_SUB 3'h0
`define OSS_SEL_FULL 3'h1
`define OSS_SEL_TOP 3'h7

// start-up edge counts of the oscillators
`define OSS_CNT_W 13
`define OSS_FAST_START 13'h0400
`define OSS_WATCH_QUICK 13'h0400
`define OSS_WATCH_LOWPWR 13'h1000

`endif

/* File: hw/oss_sync.v */
// three-stage synchroniser with agreement filter for oscillator inputs
`timescale 1ns/1ps
`default_nettype none

module oss_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // asynchronous inputs and filtered result
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end
        else
        begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // a change counts only once the last two stages agree
          if (s2_q == s3_q)
            out_q <= s3_q;
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate

endmodule // oss_sync

`default_nettype wire

/* File: hw/oss_clock_ctrl.v */
// oscillator selection and glitch-free system clock source switching
//
// Behaviour
// - the system clock comes from the fast or slow source per a select bit and a 3-bit divider, changeable at run time.
// - the fast source is the external crystal or the internal trimmed RC (8/12/16 MHz), by configuration.
// - the slow source is the internal 32 kHz RC or the 32.768 kHz watch crystal, by configuration.
// - with its enable set the crystal-frequency signal drives the shared output pins while the fast crystal runs, else low; otherwise the output is off.
// - the watch crystal runs low-power when the start-mode bit is 0 and quick-start when it is 1.
// - once the watch crystal runs, clearing the start-mode bit keeps it running at lower current.
// - the watch crystal works whatever the start-mode bit holds; low power only lengthens start-up.
// - when the watch crystal is not configured, its two pins are released to general-purpose use.
// - sleep stops the system clock, and idle does too unless fsys_on_idle is set; the slow clock keeps timers going in idle or with wdt_on_sub set.
// - the oscillators also supply the watchdog and time base clocks.
// - the watch crystal is not treated as usable until its start-up delay has passed.
// - with the select bit 0, divider codes 000/001 pick the slow clock and 010..111 the fast clock /64../2.
// - after the system clock moves from fast to slow, the fast oscillator stops and no divided fast clocks remain.
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"

module oss_clock_ctrl #(
  parameter [`OSS_CNT_W-1:0] FAST_START_EDGES = `OSS_FAST_START,
  parameter [`OSS_CNT_W-1:0] WATCH_QUICK_EDGES = `OSS_WATCH_QUICK,
  parameter [`OSS_CNT_W-1:0] WATCH_LOWPWR_EDGES = `OSS_WATCH_LOWPWR
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [`OSS_ADDR_W-1:0] reg_addr,
  input wire [`OSS_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [`OSS_DATA_W-1:0] reg_rdata,
  // configuration options, caught while reset is held
  input wire cfg_fast_is_xtal,
  input wire cfg_slow_is_xtal,
  input wire [1:0] cfg_rc_freq,
  // power state
  input wire halt,
  input wire fsys_on_idle,
  input wire wdt_on_sub,
  // raw oscillator outputs
  input wire ext_fast_crystal_clk,
  input wire int_fast_rc_clk,
  input wire ext_watch_crystal_clk,
  input wire int_slow_rc_clk,
  // oscillator controls
  output wire ext_fast_crystal_en,
  output wire int_fast_rc_en,
  output wire [1:0] int_fast_rc_freq,
  output wire ext_watch_crystal_en,
  output wire watch_xtal_quick_start,
  output wire int_slow_rc_en,
  // pin ownership
  output wire fast_xtal_pins_osc,
  output wire watch_xtal_pins_osc,
  output wire crystal_pwm_pin_o,
  output wire crystal_pwm_pin_oe_n,
  // generated clocks
  output wire sys_clk_out,
  output wire sub_clk_out,
  output wire wdt_clk_out,
  output wire timebase_clk_out
);

  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_DRAIN = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // configuration latched at reset
  reg cfg_fast_q;
  reg cfg_slow_q;
  reg [1:0] cfg_freq_q;

  // software registers
  reg [2:0] div_sel_q;
  reg fast_wake_q;
  reg idle_en_q;
  reg fast_slow_q;
  reg pwm_en_q;
  reg quick_q;
  reg [`OSS_DATA_W-1:0] rdata_q;

  // oscillator state
  reg fast_en_q;
  reg xtal_en_q;
  reg rc_en_q;
  reg slow_rc_en_q;
  reg [`OSS_CNT_W-1:0] fast_cnt_q;
  reg fast_rdy_q;
  reg [`OSS_CNT_W-1:0] watch_cnt_q;
  reg watch_rdy_q;
  reg fh_q;
  reg fsub_q;
  reg [5:0] div_q;

  // switcher state
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] cur_sel_q;
  reg [2:0] cur_sel_d;
  reg [2:0] nxt_sel_q;
  reg [2:0] nxt_sel_d;
  reg lvl_q;
  reg sys_q;
  reg sys_d;
  reg sub_q;
  reg pwm_q;
  reg pwm_oe_n_q;

  wire [3:0] osc_raw;
  wire [3:0] osc_s;

  assign osc_raw = {int_slow_rc_clk, ext_watch_crystal_clk, int_fast_rc_clk, ext_fast_crystal_clk};

  oss_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(osc_raw),
    .sync_out(osc_s)
  );

  // source muxing by configuration
  wire fh;
  wire fsub;
  wire slow_rdy;
  assign fh = cfg_fast_q ? osc_s[0] : osc_s[1];
  assign fsub = cfg_slow_q ? osc_s[2] : osc_s[3];
  // the internal slow RC needs no start-up wait; the crystal does
  assign slow_rdy = cfg_slow_q ? watch_rdy_q : 1'b1;

  // wanted source from the select bit and divider code
  wire [2:0] want_sel;
  wire fast_pending;
  wire [2:0] eff_sel;
  assign want_sel = fast_slow_q ? `OSS_SEL_FULL :
                    (div_sel_q[2:1] == 2'b00) ? `OSS_SEL_SUB : div_sel_q;
  // fast wake-up: run from the slow clock until the fast crystal is ready
  assign fast_pending = fast_wake_q & cfg_fast_q & (want_sel != `OSS_SEL_SUB) & ~fast_rdy_q;
  assign eff_sel = fast_pending ? `OSS_SEL_SUB : want_sel;

  // power state decode
  wire idle1;
  wire sys_run;
  wire sub_run;
  wire need_fast;
  wire fast_en_d;
  assign idle1 = halt & idle_en_q & fsys_on_idle;
  assign sys_run = ~halt | idle1;
  assign sub_run = ~halt | idle_en_q | wdt_on_sub;
  // fast oscillator is kept while it is wanted or something still runs from it
  assign need_fast = (want_sel != `OSS_SEL_SUB) | (cur_sel_q != `OSS_SEL_SUB) |
                     (st_q != ST_RUN);
  assign fast_en_d = need_fast & (~halt | idle1);

  // level of a selected source
  function sel_level;
    input [2:0] sel;
    input sub_lvl;
    input fast_lvl;
    input [5:0] div;
    begin
      if (sel == `OSS_SEL_SUB)
        sel_level = sub_lvl;
      else if (sel == `OSS_SEL_FULL)
        sel_level = fast_lvl;
      else
        sel_level = div[`OSS_SEL_TOP - sel];
    end
  endfunction

  wire cur_lvl;
  wire nxt_lvl;
  wire nxt_rdy;
  assign cur_lvl = sel_level(cur_sel_q, fsub, fh, div_q);
  assign nxt_lvl = sel_level(nxt_sel_q, fsub, fh, div_q);
  assign nxt_rdy = (nxt_sel_q == `OSS_SEL_SUB) ? slow_rdy : fast_rdy_q;

  // glitch-free switch: finish the old high phase, hold low, join the new
  // source only at one of its rising edges; costs up to two periods of dead time
  always @*
  begin
    st_d = st_q;
    cur_sel_d = cur_sel_q;
    nxt_sel_d = nxt_sel_q;
    sys_d = 1'b0;
    case (st_q)
      ST_RUN:
      begin
        // rises only on a source edge, so a resume never cuts a high phase short
        sys_d = cur_lvl & (sys_q | (sys_run & ~lvl_q));
        if (eff_sel != cur_sel_q)
        begin
          nxt_sel_d = eff_sel;
          st_d = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        sys_d = sys_q & cur_lvl;
        if (!sys_q)
        begin
          cur_sel_d = nxt_sel_q;
          st_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (nxt_rdy && !nxt_lvl)
          st_d = ST_RUN;
      end
      default:
      begin
        st_d = ST_RUN;
      end
    endcase
  end

  // read mux
  wire [`OSS_DATA_W-1:0] sm_val;
  wire [`OSS_DATA_W-1:0] status_val;
  assign sm_val = {div_sel_q, fast_wake_q, slow_rdy, fast_rdy_q, idle_en_q, fast_slow_q};
  assign status_val = {1'b0, st_q, cur_sel_q, cfg_slow_q, cfg_fast_q};

  // configuration capture and software registers
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      // option bits are static straps; caught while reset is held
      cfg_fast_q <= cfg_fast_is_xtal;
      cfg_slow_q <= cfg_slow_is_xtal;
      // own flop so the enable pin comes straight from a register
      slow_rc_en_q <= ~cfg_slow_is_xtal;
      cfg_freq_q <= cfg_rc_freq;
      div_sel_q <= `OSS_RST_DIV;
      fast_wake_q <= `OSS_RST_FAST_WAKE;
      idle_en_q <= `OSS_RST_IDLE_EN;
      fast_slow_q <= `OSS_RST_FAST_SLOW;
      pwm_en_q <= `OSS_RST_PWM_EN;
      quick_q <= `OSS_RST_QUICK;
      rdata_q <= {`OSS_DATA_W{1'b0}};
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `OSS_OFF_SYS_MODE:
          begin
            div_sel_q <= reg_wdata[`OSS_SM_DIV_HI:`OSS_SM_DIV_LO];
            fast_wake_q <= reg_wdata[`OSS_SM_FAST_WAKE];
            idle_en_q <= reg_wdata[`OSS_SM_IDLE_EN];
            fast_slow_q <= reg_wdata[`OSS_SM_FAST_SLOW];
          end
          `OSS_OFF_SPECIAL:
          begin
            pwm_en_q <= reg_wdata[`OSS_SC_PWM_EN];
          end
          `OSS_OFF_TIMEBASE:
          begin
            quick_q <= reg_wdata[`OSS_TB_QUICK];
          end
          default:
          begin
          end
        endcase
      end
      // read data stand only in the cycle after the strobe
      if (reg_rd)
      begin
        case (reg_addr)
          `OSS_OFF_SYS_MODE: rdata_q <= sm_val;
          `OSS_OFF_SPECIAL: rdata_q <= {{(`OSS_DATA_W-1){1'b0}}, pwm_en_q};
          `OSS_OFF_TIMEBASE: rdata_q <= {{(`OSS_DATA_W-1){1'b0}}, quick_q};
          `OSS_OFF_STATUS: rdata_q <= status_val;
          default: rdata_q <= {`OSS_DATA_W{1'b0}};
        endcase
      end
      else
      begin
        rdata_q <= {`OSS_DATA_W{1'b0}};
      end
    end
  end

  // oscillator start-up tracking and fast divider
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fast_en_q <= 1'b0;
      xtal_en_q <= 1'b0;
      rc_en_q <= 1'b0;
      fast_cnt_q <= {`OSS_CNT_W{1'b0}};
      fast_rdy_q <= 1'b0;
      watch_cnt_q <= {`OSS_CNT_W{1'b0}};
      watch_rdy_q <= 1'b0;
      fh_q <= 1'b0;
      fsub_q <= 1'b0;
      div_q <= 6'h00;
    end
    else
    begin
      fast_en_q <= fast_en_d;
      xtal_en_q <= fast_en_d & cfg_fast_q;
      rc_en_q <= fast_en_d & ~cfg_fast_q;
      fh_q <= fh;
      fsub_q <= fsub;
      if (!fast_en_q)
      begin
        // a stopped fast oscillator leaves no divided clocks behind
        fast_cnt_q <= {`OSS_CNT_W{1'b0}};
        fast_rdy_q <= 1'b0;
        div_q <= 6'h00;
      end
      else if (fh && !fh_q)
      begin
        div_q <= div_q + 6'h01;
        if (fast_cnt_q == FAST_START_EDGES)
          fast_rdy_q <= 1'b1;
        else
          fast_cnt_q <= fast_cnt_q + {{(`OSS_CNT_W-1){1'b0}}, 1'b1};
      end
      // watch crystal counts its own edges; low power needs the longer wait
      if (cfg_slow_q && !watch_rdy_q && osc_s[2] && !fsub_q)
      begin
        if (watch_cnt_q >= (quick_q ? WATCH_QUICK_EDGES : WATCH_LOWPWR_EDGES))
          watch_rdy_q <= 1'b1;
        else
          watch_cnt_q <= watch_cnt_q + {{(`OSS_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // switcher and clock outputs
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_WAIT;
      cur_sel_q <= `OSS_SEL_SUB;
      nxt_sel_q <= `OSS_SEL_SUB;
      lvl_q <= 1'b0;
      sys_q <= 1'b0;
      sub_q <= 1'b0;
      pwm_q <= 1'b0;
      pwm_oe_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cur_sel_q <= cur_sel_d;
      nxt_sel_q <= nxt_sel_d;
      lvl_q <= cur_lvl;
      sys_q <= sys_d;
      // slow clock for watchdog, time base and timers, gated the same way
      sub_q <= slow_rdy & fsub & (sub_q | (sub_run & ~fsub_q));
      // crystal-frequency copy only while the fast crystal really runs
      pwm_q <= pwm_en_q & cfg_fast_q & fast_en_q & osc_s[0];
      pwm_oe_n_q <= ~pwm_en_q;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign ext_fast_crystal_en = xtal_en_q;
  assign int_fast_rc_en = rc_en_q;
  assign int_fast_rc_freq = cfg_freq_q;
  assign ext_watch_crystal_en = cfg_slow_q;
  assign watch_xtal_quick_start = quick_q;
  assign int_slow_rc_en = slow_rc_en_q;
  assign fast_xtal_pins_osc = cfg_fast_q;
  assign watch_xtal_pins_osc = cfg_slow_q;
  assign crystal_pwm_pin_o = pwm_q;
  assign crystal_pwm_pin_oe_n = pwm_oe_n_q;
  assign sys_clk_out = sys_q;
  assign sub_clk_out = sub_q;
  assign wdt_clk_out = sub_q;
  assign timebase_clk_out = sub_q;

endmodule // oss_clock_ctrl

`default_nettype wire

/* File: verification/oss_clock_ctrl_props.sv */
// assertions for the oscillator source select block
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"
module oss_clock_ctrl_props (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [`OSS_ADDR_W-1:0] reg_addr,
  input wire [`OSS_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`OSS_DATA_W-1:0] reg_rdata,
  // power state and outputs
  input wire halt,
  input wire fsys_on_idle,
  input wire fast_xtal_pins_osc,
  input wire ext_watch_crystal_en,
  input wire watch_xtal_pins_osc,
  input wire int_slow_rc_en,
  input wire watch_xtal_quick_start,
  input wire crystal_pwm_pin_o,
  input wire crystal_pwm_pin_oe_n,
  input wire sys_clk_out
);
  logic [4:0] halt_cnt_q;
  // the current high phase may still finish, so only judge a settled halt
  always_ff @(posedge clk)
  begin
    if (!rst_n || !halt || fsys_on_idle)
      halt_cnt_q <= 5'h00;
    else if (halt_cnt_q != 5'h1F)
      halt_cnt_q <= halt_cnt_q + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PWM_OE: assert property (reg_wr && reg_addr == `OSS_OFF_SPECIAL ##1
    !(reg_wr && reg_addr == `OSS_OFF_SPECIAL) |=> crystal_pwm_pin_oe_n == !$past(reg_wdata[0], 2))
    else $error("pwm pin enable does not follow write");
  AST_PWM_OFF: assert property (crystal_pwm_pin_oe_n |-> !crystal_pwm_pin_o)
    else $error("pwm pin active while disabled");
  AST_QUICK: assert property (reg_wr && reg_addr == `OSS_OFF_TIMEBASE |=>
    watch_xtal_quick_start == $past(reg_wdata[0])) else $error("quick start bit not applied");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > `OSS_OFF_STATUS |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  AST_STATUS_CFG: assert property (reg_rd && reg_addr == `OSS_OFF_STATUS |=>
    reg_rdata[1:0] == {ext_watch_crystal_en, fast_xtal_pins_osc}) else $error("status cfg bad");
  AST_WATCH_PINS: assert property (watch_xtal_pins_osc == ext_watch_crystal_en &&
    int_slow_rc_en == !ext_watch_crystal_en) else $error("watch pin ownership wrong");
  AST_HALT_STOP: assert property (halt_cnt_q == 5'h1F |-> !$rose(sys_clk_out))
    else $error("system clock runs in halt");
  AST_SYS_HIGH: assert property ($rose(sys_clk_out) |-> sys_clk_out[*4])
    else $error("short high pulse on system clock");
  AST_SYS_LOW: assert property ($fell(sys_clk_out) |-> !sys_clk_out[*4])
    else $error("short low pulse on system clock");
  CV_PWM: cover property (reg_wr && reg_addr == `OSS_OFF_SPECIAL && reg_wdata[0]);
  CV_HALT: cover property (halt_cnt_q == 5'h1F);
  CV_LOWPWR: cover property ($fell(watch_xtal_quick_start));
endmodule // oss_clock_ctrl_props
bind oss_clock_ctrl oss_clock_ctrl_props oss_clock_ctrl_props_i (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .halt(halt), .fsys_on_idle(fsys_on_idle),
  .fast_xtal_pins_osc(fast_xtal_pins_osc), .ext_watch_crystal_en(ext_watch_crystal_en),
  .watch_xtal_pins_osc(watch_xtal_pins_osc), .int_slow_rc_en(int_slow_rc_en),
  .watch_xtal_quick_start(watch_xtal_quick_start), .crystal_pwm_pin_o(crystal_pwm_pin_o),
  .crystal_pwm_pin_oe_n(crystal_pwm_pin_oe_n), .sys_clk_out(sys_clk_out));
`default_nettype wire

/* File: verification/oss_clock_ctrl_test.sv */
// self-checking bench for the oscillator source select block
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module oss_clock_ctrl_test;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, halt = 0, fsys_on_idle = 0, wdt_on_sub = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic cfg_fast = 1, cfg_slow = 1, fx = 0, fr = 0, wx = 0, sr = 0;
  logic [1:0] cfg_rc = 2'h2;
  wire logic [7:0] reg_rdata;
  wire logic fx_en, fr_en, wx_en, quick, sr_en, fpins, wpins, pwm_o, pwm_oe_n, sys, sub, wdt, tb;
  wire logic [1:0] rc_freq;
  int miscompares = 0, tests_run = 0, cycles = 0;
  oss_clock_ctrl #(.FAST_START_EDGES(13'h0004), .WATCH_QUICK_EDGES(13'h0004),
    .WATCH_LOWPWR_EDGES(13'h0008)) oss_clock_ctrl_i (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_fast_is_xtal(cfg_fast), .cfg_slow_is_xtal(cfg_slow),
    .cfg_rc_freq(cfg_rc), .halt(halt), .fsys_on_idle(fsys_on_idle), .wdt_on_sub(wdt_on_sub),
    .ext_fast_crystal_clk(fx), .int_fast_rc_clk(fr), .ext_watch_crystal_clk(wx),
    .int_slow_rc_clk(sr), .ext_fast_crystal_en(fx_en), .int_fast_rc_en(fr_en),
    .int_fast_rc_freq(rc_freq), .ext_watch_crystal_en(wx_en), .watch_xtal_quick_start(quick),
    .int_slow_rc_en(sr_en), .fast_xtal_pins_osc(fpins), .watch_xtal_pins_osc(wpins),
    .crystal_pwm_pin_o(pwm_o), .crystal_pwm_pin_oe_n(pwm_oe_n), .sys_clk_out(sys),
    .sub_clk_out(sub), .wdt_clk_out(wdt), .timebase_clk_out(tb));
  always #5 clk = !clk;
  // oscillators only swing while enabled, at phases unrelated to clk
  always #100.3 fx = fx_en ? !fx : 1'b0;
  always #99.7 fr = fr_en ? !fr : 1'b0;
  always #1000.1 wx = wx_en ? !wx : 1'b0;
  always #1003.7 sr = sr_en ? !sr : 1'b0;
  task finish_test;
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      finish_test;
    end
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata & m, e)
  endtask
  // counts rising edges of one generated clock over a window, expects exp +-1
  task rate(input int which, input int win, input int exp);
    logic p, s;
    int n;
    n = 0;
    p = 1'b1;
    repeat (win)
    begin
      @(posedge clk);
      #1 s = which == 0 ? sys : which == 1 ? sub : which == 2 ? pwm_o : which == 3 ? wdt : tb;
      if (s === 1'b1 && p === 1'b0)
        n++;
      p = s;
    end
    `CHK(n >= exp - 1 && n <= exp + 1, 1'b1)
  endtask
  task t_reset;
    `CHK({pwm_oe_n, quick, sub}, 3'b110)
    `CHK({wx_en, wpins, sr_en, fpins, rc_freq}, 6'b110110)
    rchk(`OSS_OFF_SYS_MODE, 8'hE2, 8'hFB);
    rchk(`OSS_OFF_SPECIAL, 8'h00, 8'hFF);
    rchk(`OSS_OFF_TIMEBASE, 8'h01, 8'hFF);
    rchk(4'h9, 8'h00, 8'hFF);
  endtask
  task t_div;
    for (int c = 2; c < 8; c++)
    begin
      wr(`OSS_OFF_SYS_MODE, {c[2:0], 5'h02});
      repeat (4000) @(posedge clk);
      rate(0, 160 << (7 - c), 4);
      rchk(`OSS_OFF_STATUS, {3'h0, c[2:0], 2'h3}, 8'h1F);
    end
  endtask
  task t_pwm;
    // shared pins count as routed to the crystal copy only after the enable is written
    wr(`OSS_OFF_SPECIAL, 8'h01);
    repeat (2) @(posedge clk);
    #1 `CHK(pwm_oe_n, 1'b0)
    rate(2, 80, 4);
    wr(`OSS_OFF_SPECIAL, 8'h00);
    repeat (3) @(posedge clk);
    #1 `CHK({pwm_oe_n, pwm_o}, 2'b10)
  endtask
  task t_full;
    wr(`OSS_OFF_SYS_MODE, 8'hE3);
    repeat (4000) @(posedge clk);
    rate(0, 80, 4);
    rchk(`OSS_OFF_STATUS, 8'h07, 8'h1F);
  endtask
  task t_slow;
    for (int c = 0; c < 2; c++)
    begin
      wr(`OSS_OFF_SYS_MODE, {c[2:0], 5'h02});
      repeat (4000) @(posedge clk);
      rate(0, 800, 4);
      rchk(`OSS_OFF_STATUS, 8'h03, 8'h1F);
      `CHK(fx_en, 1'b0)
    end
    rchk(`OSS_OFF_SYS_MODE, 8'h08, 8'h08);
  endtask
  task t_quick;
    wr(`OSS_OFF_TIMEBASE, 8'h00);
    #1 `CHK(quick, 1'b0)
    rate(1, 800, 4);
    rate(3, 800, 4);
    rate(4, 800, 4);
    `CHK(wx_en, 1'b1)
    wr(`OSS_OFF_TIMEBASE, 8'h01);
    #1 `CHK(quick, 1'b1)
  endtask
  task t_halt;
    @(posedge clk);
    wdt_on_sub <= 1'b1;
    halt <= 1'b1;
    repeat (500) @(posedge clk);
    rate(0, 800, 0);
    rate(1, 800, 4);
    @(posedge clk);
    fsys_on_idle <= 1'b1;
    repeat (1000) @(posedge clk);
    rate(0, 800, 4);
    @(posedge clk);
    halt <= 1'b0;
    fsys_on_idle <= 1'b0;
  endtask
  task t_cfg;
    @(posedge clk);
    rst_n <= 1'b0;
    cfg_fast <= 1'b0;
    cfg_slow <= 1'b0;
    cfg_rc <= 2'h1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({wx_en, wpins, sr_en, fpins, rc_freq}, 6'b001001)
    repeat (4000) @(posedge clk);
    rate(0, 160, 4);
    `CHK({fx_en, fr_en}, 2'b01)
    rchk(`OSS_OFF_STATUS, 8'h1C, 8'h1F);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_div;
    t_pwm;
    t_full;
    t_slow;
    t_quick;
    t_halt;
    t_cfg;
    finish_test;
  end
endmodule // oss_clock_ctrl_test
`default_nettype wire
